// *** inc/tcas_defines.vh ***
/*
 * constants for the type-c audio switch control/status block: register
 * offsets, field positions, reset values and timing counts.
 * assumes a 125 MHz system clock; included by bare name.
 */
`ifndef TCAS_DEFINES_VH
`define TCAS_DEFINES_VH

// i2c
`define TCAS_I2C_ADDR 7'h42
`define TCAS_I2C_RATE_HZ 400000
// register offsets
`define TCAS_OFS_FUNC_EN 8'h12
`define TCAS_OFS_JACK_STATUS 8'h17
`define TCAS_OFS_CC_STATUS 8'h11
`define TCAS_OFS_EVENT_FLAGS 8'h18
`define TCAS_OFS_MIC_TH_LO 8'h1c
`define TCAS_OFS_MIC_TH_HI 8'h1d
`define TCAS_OFS_SOFT_RESET 8'h1e
`define TCAS_OFS_CUR_SRC 8'h1f
`define TCAS_OFS_WDOG_CFG 8'h20
`define TCAS_OFS_LEFT_DELAY 8'h21
// reset values
`define TCAS_RST_FUNC_EN 8'h00
`define TCAS_RST_MIC_TH_LO 8'h20
`define TCAS_RST_MIC_TH_HI 8'hff
`define TCAS_RST_CUR_SRC 4'h7
`define TCAS_RST_WDOG_CFG 8'h01
`define TCAS_RST_LEFT_DELAY 8'h00
`define TCAS_RST_JACK_STATUS 8'h01
// fields
`define TCAS_EVT_WDOG_BIT 3
`define TCAS_EVT_DETECT_BIT 2
`define TCAS_FEN_DETECT_BIT 0
`define TCAS_FEN_AUTOBRK_BIT 2
`define TCAS_WD_EN_BIT 7
`define TCAS_WD_SERVICE_BIT 3
// timing
`define TCAS_CLK_HZ 125000000
`define TCAS_CLK_NS 8
`define TCAS_DELAY_STEP_US 400
`define TCAS_DELAY_STEP_CYC ((`TCAS_DELAY_STEP_US * 1000) / `TCAS_CLK_NS)
`define TCAS_MICGND_US 50
`define TCAS_MICGND_CYC ((`TCAS_MICGND_US * 1000 + `TCAS_CLK_NS - 1) / `TCAS_CLK_NS)
`define TCAS_WD_HALF_SEC_MS 500
`define TCAS_WD_HALF_SEC_CYC ((`TCAS_WD_HALF_SEC_MS * 125000))

`endif

// *** hdl/tcas_ctrl.v ***
/*
 * control/status logic of a type-c audio switch behind an i2c slave port.
 * assumes SCL/SDA and the analog detector levels come from outside the
 * SYS_CLK domain; the analog switch matrix sits outside and follows
 * the switch enables driven here.
 */
// How it works
// R01: bit3: sbu2 mic, sbu1 ground headset
// R02: bit2: sbu1 mic, sbu2 ground headset
// R03: bit1 three-contact, bit0 nothing attached
// R04: bit3 flag on guard timeout, read clears
// R05: bit2 flag when detection completes
// R06: threshold low resets to 0x20
// R07: threshold high resets to 0xff
// R08: soft reset bit resets register logic
// R09: 4-bit current code, resets to 0111
// R10: guard enable at bit 7
// R11: 3-bit period selects 0.5s to 5min
// R12: unserviced guard forces first usb path
// R13: left switch delayed code times 400us
// R14: overvoltage opens path, flags the pin
// R15: cc level reported as two bits
// R16: auto-break only with enable bit 2
// R17: cc rise grounds mic pin 50us
// R18: detection runs while enable bit 0
// R19: switches open during detection
// R20: switches close per detected type
// R21: i2c slave, fast mode 400kHz
// R22: master stops after single read byte
// R23: detection enable self-clears when done
// R24: overvoltage threshold field, resets 00
// R25: write: addr, reg, data; read repeated start
// R26: read-clear only after byte was sent
`timescale 1ns/1ps
`default_nettype none
`include "tcas_defines.vh"

module tcas_ctrl #(
    parameter [31:0] WD_HALF_SEC_CYC = `TCAS_WD_HALF_SEC_CYC, // shorten in sim
    parameter [31:0] STEP_CYC = `TCAS_DELAY_STEP_CYC // 400us step, shorten in sim
) (
    input wire SYS_CLK,
    input wire RST,
    input wire SCL_IN,
    input wire SDA_IN,
    output reg SDA_OE,
    input wire CC_SENSE_INPUT,
    input wire [3:0] OVP_TRIP,
    input wire [1:0] PLUG_TYPE,
    input wire DETECT_DONE,
    output reg DETECT_RUN,
    output reg [7:0] MIC_TH_LO,
    output reg [7:0] MIC_TH_HI,
    output reg [3:0] CUR_SRC,
    output reg [1:0] OVP_LEVEL,
    output reg [3:0] OVP_FLAGS,
    output reg [3:0] PATH_OPEN,
    output reg FIRST_USB_PATH,
    output reg SW_RIGHT,
    output reg SW_LEFT,
    output reg SW_GND_SENSE,
    output reg SW_MIC,
    output reg SW_AUDIO_GND,
    output reg MIC_PIN_GND
);
    // two-flop synchronisers; first stage read only by second
    reg [9:0] s1_q;
    reg [9:0] s2_q;
    reg scl_d_q; // delayed synced scl for edges
    reg sda_d_q;
    always @(posedge SYS_CLK) begin
        if (RST) begin
            s1_q <= 10'h003;
            s2_q <= 10'h003;
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            s1_q <= {PLUG_TYPE, OVP_TRIP, DETECT_DONE, CC_SENSE_INPUT, SDA_IN, SCL_IN};
            s2_q <= s1_q;
            scl_d_q <= s2_q[0];
            sda_d_q <= s2_q[1];
        end
    end
    wire scl = s2_q[0];
    wire sda = s2_q[1];
    wire cc_lvl = s2_q[2];
    wire det_done = s2_q[3];
    wire [3:0] overvoltage_shutoff = s2_q[7:4];
    wire [1:0] plug = s2_q[9:8];
    wire scl_rise = scl & ~scl_d_q;
    wire scl_fall = ~scl & scl_d_q;
    wire start_c = scl & scl_d_q & sda_d_q & ~sda; // R21
    wire stop_c = scl & scl_d_q & ~sda_d_q & sda;

    // i2c slave states, one-hot
    localparam [5:0] ST_IDLE = 6'b000001;
    localparam [5:0] ST_ADDR = 6'b000010;
    localparam [5:0] ST_REG = 6'b000100;
    localparam [5:0] ST_WDATA = 6'b001000;
    localparam [5:0] ST_RDATA = 6'b010000;
    localparam [5:0] ST_RACK = 6'b100000;
    reg [5:0] st_q;
    reg [3:0] bit_q; // bit count, 8 = ack slot
    reg [7:0] sh_q; // shift register
    reg [7:0] ptr_q; // register pointer
    reg ack_q; // we drive ack in this slot
    reg rd_evt_q; // event register byte sent, clear pending
    reg wr_q; // one-cycle write strobe
    reg [7:0] wr_addr_q;
    reg [7:0] wr_data_q;

    // register file
    reg [7:0] fen_q; // function enable
    reg [7:0] wd_q; // guard config
    reg [7:0] ldly_q; // left delay code
    reg [7:0] evt_q; // event flags
    reg [7:0] jack_q; // jack status
    reg sreset; // soft reset pulse

    // read mux
    reg [7:0] rd_val;
    always @* begin
        case (ptr_q)
            `TCAS_OFS_FUNC_EN: rd_val = fen_q;
            `TCAS_OFS_CC_STATUS: rd_val = {6'h00, cc_lvl, ~cc_lvl}; // R15
            `TCAS_OFS_JACK_STATUS: rd_val = jack_q;
            `TCAS_OFS_EVENT_FLAGS: rd_val = evt_q;
            `TCAS_OFS_MIC_TH_LO: rd_val = MIC_TH_LO;
            `TCAS_OFS_MIC_TH_HI: rd_val = MIC_TH_HI;
            `TCAS_OFS_SOFT_RESET: rd_val = 8'h00; // R08
            `TCAS_OFS_CUR_SRC: rd_val = {4'h0, CUR_SRC};
            `TCAS_OFS_WDOG_CFG: rd_val = wd_q;
            `TCAS_OFS_LEFT_DELAY: rd_val = ldly_q;
            default: rd_val = 8'h00; // unmapped reads zero
        endcase
    end

    // i2c slave engine; soft reset leaves a transfer alive
    always @(posedge SYS_CLK) begin
        wr_q <= 1'b0;
        rd_evt_q <= 1'b0;
        if (RST) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            ack_q <= 1'b0;
            SDA_OE <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else if (start_c) begin
            st_q <= ST_ADDR; // R25
            bit_q <= 4'h0;
            SDA_OE <= 1'b0;
            ack_q <= 1'b0;
        end else if (stop_c) begin
            st_q <= ST_IDLE; // R22
            SDA_OE <= 1'b0;
        end else if (scl_rise && !(st_q == ST_IDLE)) begin
            if (bit_q != 4'h8) begin
                sh_q <= {sh_q[6:0], sda};
                bit_q <= bit_q + 4'h1;
            end else begin
                bit_q <= 4'h0;
                if (st_q == ST_RACK && sda)
                    st_q <= ST_IDLE; // master nack ends read
            end
        end else if (scl_fall && !(st_q == ST_IDLE)) begin
            if (bit_q == 4'h8) begin
                // ack slot begins
                case (st_q)
                    ST_ADDR: begin
                        if (sh_q[7:1] == `TCAS_I2C_ADDR) begin
                            ack_q <= 1'b1;
                            SDA_OE <= 1'b1;
                            st_q <= sh_q[0] ? ST_RDATA : ST_REG;
                        end else begin
                            st_q <= ST_IDLE; // not ours
                        end
                    end
                    ST_REG: begin
                        ptr_q <= sh_q; // R25
                        SDA_OE <= 1'b1;
                        st_q <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        wr_q <= 1'b1;
                        wr_addr_q <= ptr_q;
                        wr_data_q <= sh_q;
                        ptr_q <= ptr_q + 8'h01;
                        SDA_OE <= 1'b1;
                    end
                    ST_RACK: begin
                        SDA_OE <= 1'b0; // master acks
                        if (ptr_q == `TCAS_OFS_EVENT_FLAGS)
                            rd_evt_q <= 1'b1; // R26
                        ptr_q <= ptr_q + 8'h01;
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end else if (bit_q == 4'h0 && st_q == ST_RDATA && ack_q) begin
                // ack done, load first read bit
                ack_q <= 1'b0;
                sh_q <= rd_val;
                SDA_OE <= ~rd_val[7];
                st_q <= ST_RACK;
            end else if (bit_q == 4'h0 && st_q == ST_RACK) begin
                sh_q <= rd_val; // next byte after master ack
                SDA_OE <= ~rd_val[7];
            end else if (st_q == ST_RACK) begin
                SDA_OE <= ~sh_q[7]; // shifted value drives next bit
            end else begin
                SDA_OE <= 1'b0; // release after ack
            end
        end
    end

    localparam [3:0] DS_IDLE = 4'b0001;
    localparam [3:0] DS_RUN = 4'b0010;
    localparam [3:0] DS_WAIT = 4'b0100;
    localparam [3:0] DS_ON = 4'b1000;
    reg [3:0] ds_q;
    reg [15:0] ldly_cyc_q; // cycles within one step
    reg [7:0] ldly_cnt_q; // steps done
    wire det_fin = (ds_q == DS_RUN) && det_done;
    reg cc_d_q;
    reg [13:0] gnd_cnt_q;
    localparam [13:0] GND_CYC = `TCAS_MICGND_CYC;
    wire autobrk = fen_q[`TCAS_FEN_AUTOBRK_BIT] && SW_LEFT && SW_RIGHT && SW_AUDIO_GND; // R16

    // register writes; soft reset is write-and-clear
    always @(posedge SYS_CLK) begin
        sreset <= 1'b0;
        if (RST || sreset) begin
            fen_q <= `TCAS_RST_FUNC_EN; // R24
            MIC_TH_LO <= `TCAS_RST_MIC_TH_LO; // R06
            MIC_TH_HI <= `TCAS_RST_MIC_TH_HI; // R07
            CUR_SRC <= `TCAS_RST_CUR_SRC; // R09
            wd_q <= `TCAS_RST_WDOG_CFG;
            ldly_q <= `TCAS_RST_LEFT_DELAY;
        end else begin
            if (wr_q) begin
                case (wr_addr_q)
                    `TCAS_OFS_FUNC_EN: fen_q <= wr_data_q;
                    `TCAS_OFS_MIC_TH_LO: MIC_TH_LO <= wr_data_q;
                    `TCAS_OFS_MIC_TH_HI: MIC_TH_HI <= wr_data_q;
                    `TCAS_OFS_SOFT_RESET: sreset <= wr_data_q[0]; // R08
                    `TCAS_OFS_CUR_SRC: CUR_SRC <= wr_data_q[3:0]; // R09
                    `TCAS_OFS_WDOG_CFG: wd_q <= {wr_data_q[7], 3'b000, wr_data_q[3:0]}; // R10
                    `TCAS_OFS_LEFT_DELAY: ldly_q <= wr_data_q;
                    default: ;
                endcase
            end
            if (det_fin)
                fen_q[`TCAS_FEN_DETECT_BIT] <= 1'b0; // R23
        end
    end

    // guard timer: period table in half seconds
    reg [9:0] halves;
    always @* begin
        case (wd_q[2:0]) // R11
            3'd0: halves = 10'd1;
            3'd1: halves = 10'd2;
            3'd2: halves = 10'd4;
            3'd3: halves = 10'd10;
            3'd4: halves = 10'd20;
            3'd5: halves = 10'd60;
            3'd6: halves = 10'd120;
            default: halves = 10'd600;
        endcase
    end
    reg [31:0] wd_cyc_q;
    reg [9:0] wd_half_q;
    reg wd_exp_q; // expiry pulse
    always @(posedge SYS_CLK) begin
        wd_exp_q <= 1'b0;
        if (RST || sreset || !wd_q[`TCAS_WD_EN_BIT] || wd_q[`TCAS_WD_SERVICE_BIT]) begin
            wd_cyc_q <= 32'h0000_0000; // R10
            wd_half_q <= 10'h000;
        end else if (wd_cyc_q == WD_HALF_SEC_CYC - 32'h0000_0001) begin
            wd_cyc_q <= 32'h0000_0000;
            if (wd_half_q == halves - 10'h001) begin
                wd_half_q <= 10'h000;
                wd_exp_q <= 1'b1; // R12
            end else begin
                wd_half_q <= wd_half_q + 10'h001;
            end
        end else begin
            wd_cyc_q <= wd_cyc_q + 32'h0000_0001;
        end
    end

    // detection sequencer, one-hot
    always @(posedge SYS_CLK) begin
        if (RST || sreset || wd_exp_q) begin
            ds_q <= DS_IDLE;
            DETECT_RUN <= 1'b0;
            jack_q <= `TCAS_RST_JACK_STATUS;
            {SW_RIGHT, SW_LEFT, SW_GND_SENSE, SW_MIC, SW_AUDIO_GND} <= 5'b00000;
            ldly_cyc_q <= 16'h0000;
            ldly_cnt_q <= 8'h00;
        end else begin
            case (ds_q)
                DS_IDLE: begin
                    if (fen_q[`TCAS_FEN_DETECT_BIT]) begin // R18
                        ds_q <= DS_RUN;
                        DETECT_RUN <= 1'b1;
                        {SW_RIGHT, SW_LEFT, SW_GND_SENSE, SW_MIC, SW_AUDIO_GND} <= 5'b00000; // R19
                    end
                end
                DS_RUN: begin
                    if (det_done) begin
                        DETECT_RUN <= 1'b0;
                        case (plug) // R01 R02 R03
                            2'd1: jack_q <= 8'h08; // R01
                            2'd2: jack_q <= 8'h04; // R02
                            2'd3: jack_q <= 8'h02; // R03
                            default: jack_q <= 8'h01; // R03
                        endcase
                        ds_q <= (plug == 2'd0) ? DS_IDLE : DS_WAIT;
                        SW_RIGHT <= (plug != 2'd0); // R20
                        SW_GND_SENSE <= (plug != 2'd0);
                        SW_AUDIO_GND <= (plug != 2'd0);
                        SW_MIC <= plug[1] ^ plug[0]; // four-contact only
                        ldly_cyc_q <= 16'h0000;
                        ldly_cnt_q <= 8'h00;
                    end
                end
                DS_WAIT: begin
                    // left switch held off for code x 400us
                    if (ldly_cnt_q == ldly_q) begin
                        SW_LEFT <= 1'b1; // R13
                        ds_q <= DS_ON;
                    end else if (ldly_cyc_q == STEP_CYC[15:0] - 16'h0001) begin
                        ldly_cyc_q <= 16'h0000;
                        ldly_cnt_q <= ldly_cnt_q + 8'h01; // R13
                    end else begin
                        ldly_cyc_q <= ldly_cyc_q + 16'h0001;
                    end
                end
                DS_ON: begin
                    if (fen_q[`TCAS_FEN_DETECT_BIT])
                        ds_q <= DS_IDLE; // rerun requested
                    if (gnd_cnt_q != 14'h0000 || (cc_lvl && !cc_d_q && autobrk))
                        SW_MIC <= 1'b0; // R17
                end
                default: ds_q <= DS_IDLE;
            endcase
        end
    end

    // mic auto-break: ground pulse then high-z
    always @(posedge SYS_CLK) begin
        if (RST || sreset) begin
            cc_d_q <= 1'b0;
            gnd_cnt_q <= 14'h0000;
            MIC_PIN_GND <= 1'b0;
        end else begin
            cc_d_q <= cc_lvl;
            if (cc_lvl && !cc_d_q && autobrk) begin
                gnd_cnt_q <= GND_CYC; // R17
                MIC_PIN_GND <= 1'b1;
            end else if (gnd_cnt_q != 14'h0000) begin
                gnd_cnt_q <= gnd_cnt_q - 14'h0001;
                MIC_PIN_GND <= (gnd_cnt_q != 14'h0001);
            end
        end
    end

    // event flags: set wins over read-clear
    always @(posedge SYS_CLK) begin
        if (RST || sreset) begin
            evt_q <= 8'h00; // R04
        end else begin
            evt_q <= (rd_evt_q ? 8'h00 : evt_q) // R26
                | ({7'h00, wd_exp_q} << `TCAS_EVT_WDOG_BIT) // R04
                | ({7'h00, det_fin} << `TCAS_EVT_DETECT_BIT); // R05
        end
    end

    // overvoltage, threshold level and usb fallback
    always @(posedge SYS_CLK) begin
        if (RST || sreset) begin
            OVP_LEVEL <= 2'b00;
            OVP_FLAGS <= 4'h0;
            PATH_OPEN <= 4'h0;
            FIRST_USB_PATH <= 1'b0;
        end else begin
            OVP_LEVEL <= fen_q[7:6]; // R24 R14
            OVP_FLAGS <= OVP_FLAGS | overvoltage_shutoff; // R14
            PATH_OPEN <= overvoltage_shutoff; // R14
            if (wd_exp_q)
                FIRST_USB_PATH <= 1'b1; // R12
            else if (ds_q == DS_RUN)
                FIRST_USB_PATH <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** testbench/tcas_monitor.sv ***
/*
 * assertion checker for the audio switch control block, bound to its ports.
 * assumes plain synchronous logic on SYS_CLK with RST active high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tcas_defines.vh"
module tcas_monitor (
    input wire SYS_CLK,
    input wire RST,
    input wire SCL_IN,
    input wire SDA_OE,
    input wire [3:0] OVP_TRIP,
    input wire [1:0] PLUG_TYPE,
    input wire DETECT_DONE,
    input wire DETECT_RUN,
    input wire [7:0] MIC_TH_LO,
    input wire [7:0] MIC_TH_HI,
    input wire [3:0] CUR_SRC,
    input wire [3:0] OVP_FLAGS,
    input wire [3:0] PATH_OPEN,
    input wire FIRST_USB_PATH,
    input wire SW_RIGHT,
    input wire SW_LEFT,
    input wire SW_GND_SENSE,
    input wire SW_MIC,
    input wire SW_AUDIO_GND,
    input wire MIC_PIN_GND
);
    localparam int GND_CYC = `TCAS_MICGND_CYC; // ground pulse length in cycles
    logic [15:0] gnd_cnt_q; // cycles the mic pin has been grounded
    wire any_sw = SW_RIGHT | SW_LEFT | SW_GND_SENSE | SW_MIC | SW_AUDIO_GND;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // count pulse length; restart whenever the pin is released
    always @(posedge SYS_CLK) begin
        if (RST || !MIC_PIN_GND) begin
            gnd_cnt_q <= 16'h0000;
        end else begin
            gnd_cnt_q <= gnd_cnt_q + 16'h0001;
        end
    end
    reset_values_a: assert property ($fell(RST) |-> MIC_TH_LO == 8'h20 &&
        MIC_TH_HI == 8'hff && CUR_SRC == 4'h7) else $error("register outputs off after reset");
    detect_open_a: assert property (DETECT_RUN && $past(DETECT_RUN) |-> !any_sw)
        else $error("switch closed during detection");
    done_clears_a: assert property ($rose(DETECT_DONE) ##5 DETECT_DONE |-> !DETECT_RUN)
        else $error("detection still running after done");
    close_a: assert property ($fell(DETECT_RUN) && PLUG_TYPE == 2'd1 |->
        ##[0:3] (SW_RIGHT && SW_MIC && SW_AUDIO_GND)) else $error("switches not closed");
    ground_len_a: assert property ($fell(MIC_PIN_GND) |->
        gnd_cnt_q >= GND_CYC - 1 && gnd_cnt_q <= GND_CYC + 1) else $error("ground pulse length");
    break_cond_a: assert property ($rose(MIC_PIN_GND) |-> SW_LEFT && SW_RIGHT && SW_AUDIO_GND)
        else $error("ground pulse without audio switches on");
    mic_open_a: assert property (MIC_PIN_GND && $past(MIC_PIN_GND) |-> !SW_MIC)
        else $error("mic switch on while pin grounded");
    guard_open_a: assert property ($rose(FIRST_USB_PATH) |=> !any_sw)
        else $error("switches left on after guard expiry");
    run_clears_usb_a: assert property ($rose(DETECT_RUN) |-> ##[0:2] !FIRST_USB_PATH)
        else $error("usb default kept while detecting");
    ovp_flag_a: assert property ($stable(OVP_TRIP) [*4] |->
        (OVP_FLAGS & OVP_TRIP) == OVP_TRIP && (PATH_OPEN & OVP_TRIP) == OVP_TRIP)
        else $error("overvoltage not flagged");
    sda_quiet_a: assert property ($changed(SDA_OE) |-> !SCL_IN)
        else $error("data line moved while clock high");
    cover property ($fell(MIC_PIN_GND));
    cover property ($rose(FIRST_USB_PATH));
    cover property ($fell(DETECT_RUN) && PLUG_TYPE == 2'd1);
endmodule
bind tcas_ctrl tcas_monitor mon (.SYS_CLK(SYS_CLK), .RST(RST), .SCL_IN(SCL_IN),
    .SDA_OE(SDA_OE), .OVP_TRIP(OVP_TRIP), .PLUG_TYPE(PLUG_TYPE), .DETECT_DONE(DETECT_DONE),
    .DETECT_RUN(DETECT_RUN), .MIC_TH_LO(MIC_TH_LO), .MIC_TH_HI(MIC_TH_HI),
    .CUR_SRC(CUR_SRC), .OVP_FLAGS(OVP_FLAGS), .PATH_OPEN(PATH_OPEN),
    .FIRST_USB_PATH(FIRST_USB_PATH), .SW_RIGHT(SW_RIGHT), .SW_LEFT(SW_LEFT),
    .SW_GND_SENSE(SW_GND_SENSE), .SW_MIC(SW_MIC), .SW_AUDIO_GND(SW_AUDIO_GND),
    .MIC_PIN_GND(MIC_PIN_GND));
`default_nettype wire

// *** testbench/tcas_host.sv ***
/*
 * i2c master model standing in for the host processor.
 * assumes the bench ands both pull-downs into one open-drain data wire.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tcas_defines.vh"
module tcas_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic pull
);
    // bus idles released, clock high
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one bit of a ten-cycle period; data moves only while clock low
    task automatic bit_io(input logic b, output logic r);
        tick(3);
        pull <= ~b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        r = sda; // late in the high phase, data has settled
        scl <= 1'b0;
        tick(1);
    endtask
    // start and repeated start alike: data falls while clock high
    task automatic start();
        tick(3);
        pull <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(3);
        pull <= 1'b1;
        tick(2);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(3);
        pull <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(3);
        pull <= 1'b0;
        tick(5);
    endtask
    // eight bits msb first, then the ninth slot driven with last
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(last, r);
        ack = ~r;
    endtask
    task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] dat,
        output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        xfer({dev, 1'b0}, 1'b1, q, a0);
        xfer(ofs, 1'b1, q, a1);
        xfer(dat, 1'b1, q, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] dat);
        logic [7:0] q;
        logic a;
        start();
        xfer({`TCAS_I2C_ADDR, 1'b0}, 1'b1, q, a);
        xfer(ofs, 1'b1, q, a);
        start();
        xfer({`TCAS_I2C_ADDR, 1'b1}, 1'b1, q, a);
        xfer(8'hff, 1'b1, dat, a); // not acked, stop follows
        stop();
    endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
/*
 * self-checking bench for the audio switch control block.
 * assumes the i2c host model in tcas_host and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tcas_defines.vh"
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cc = 1'b0;
    logic done = 1'b0;
    logic [3:0] trip = 4'h0;
    logic [1:0] plug = 2'd0;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    wire scl, pull, sda_oe, run, usb, sr, sl, sg, sm, sa, mg;
    wire [7:0] th_lo, th_hi;
    wire [3:0] cur, ovf, pth;
    wire [1:0] ovl;
    wire sda = ~(sda_oe | pull); // open drain with pull-up
    always #4 clk = ~clk;
    tcas_host host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
    // short guard and delay steps keep the run brief
    tcas_ctrl #(.WD_HALF_SEC_CYC(50), .STEP_CYC(4)) dut (.SYS_CLK(clk), .RST(rst),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OE(sda_oe), .CC_SENSE_INPUT(cc), .OVP_TRIP(trip),
        .PLUG_TYPE(plug), .DETECT_DONE(done), .DETECT_RUN(run), .MIC_TH_LO(th_lo),
        .MIC_TH_HI(th_hi), .CUR_SRC(cur), .OVP_LEVEL(ovl), .OVP_FLAGS(ovf), .PATH_OPEN(pth),
        .FIRST_USB_PATH(usb), .SW_RIGHT(sr), .SW_LEFT(sl), .SW_GND_SENSE(sg), .SW_MIC(sm),
        .SW_AUDIO_GND(sa), .MIC_PIN_GND(mg));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp, input string what);
        logic [7:0] v;
        host.rd_reg(ofs, v);
        chk(v, exp, what);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic ok;
        host.wr_reg(`TCAS_I2C_ADDR, ofs, d, ok);
        chk(ok, 1, "write ack");
    endtask
    task automatic t_reset();
        logic [7:0] ofs [8] = '{8'h18, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h17};
        logic [7:0] exp [8] = '{8'h00, 8'h20, 8'hff, 8'h00, 8'h07, 8'h01, 8'h00, 8'h01};
        for (int i = 0; i < 8; i++) begin
            rchk(ofs[i], exp[i], "reset value");
        end
        chk({th_lo[3:0], cur}, 8'h07, "port reset");
        $display("test reset done");
    endtask
    task automatic t_rw();
        logic ok;
        logic [3:0] codes [3] = '{4'hf, 4'h7, 4'h1};
        wr(8'h1c, 8'h5a);
        wr(8'h1d, 8'ha5);
        rchk(8'h1c, 8'h5a, "threshold low");
        rchk(8'h1d, 8'ha5, "threshold high");
        chk(th_hi, 8'ha5, "threshold port");
        foreach (codes[i]) begin
            wr(8'h1f, {4'h0, codes[i]});
            rchk(8'h1f, {4'h0, codes[i]}, "current code");
            chk(cur, codes[i], "current port");
        end
        wr(8'h30, 8'h3c);
        rchk(8'h30, 8'h00, "unmapped");
        host.wr_reg(~`TCAS_I2C_ADDR, 8'h1c, 8'h00, ok);
        chk(ok, 0, "foreign address ack");
        rchk(8'h1c, 8'h5a, "foreign write ignored");
        $display("test register access done");
    endtask
    task automatic t_detect(input logic [1:0] t, input logic [7:0] s);
        plug <= t;
        wr(8'h21, 8'h05);
        wr(8'h12, 8'h01);
        chk(run, 1, "detect running");
        chk({sr, sl, sg, sm, sa}, 0, "switches open");
        done <= 1'b1;
        host.tick(6);
        chk({sr, sl, sg}, 8'h05, "right on, left held");
        host.tick(30);
        chk(sl, 1, "left on after delay");
        done <= 1'b0;
        rchk(8'h17, s, "jack status");
        rchk(8'h18, 8'h04, "detect flag");
        rchk(8'h18, 8'h00, "flag cleared");
        rchk(8'h12, 8'h00, "enable self clear");
        $display("test detect done");
    endtask
    task automatic t_cc();
        rchk(8'h11, 8'h01, "cc low");
        cc <= 1'b1;
        host.tick(8);
        chk(mg, 0, "no break when disabled");
        cc <= 1'b0;
        wr(8'h12, 8'h04);
        cc <= 1'b1;
        host.tick(8);
        chk({mg, sm}, 8'h02, "mic grounded and open");
        host.tick(`TCAS_MICGND_CYC);
        chk(mg, 0, "ground released");
        rchk(8'h11, 8'h02, "cc high");
        $display("test cc done");
    endtask
    task automatic t_wdog();
        wr(8'h20, 8'h80);
        host.tick(110);
        chk(usb, 1, "guard fired");
        chk({sr, sl, sm, sa}, 0, "switches dropped");
        wr(8'h20, 8'h88);
        rchk(8'h18, 8'h08, "guard flag");
        rchk(8'h18, 8'h00, "serviced guard quiet");
        wr(8'h20, 8'h01);
        $display("test guard done");
    endtask
    task automatic t_ovp();
        trip <= 4'hf;
        host.tick(6);
        chk({ovf, pth}, 8'hff, "trip flagged");
        trip <= 4'h0;
        host.tick(6);
        chk({ovf, pth}, 8'hf0, "flag sticky");
        wr(8'h12, 8'hc0);
        chk(ovl, 8'h03, "threshold field");
        $display("test overvoltage done");
    endtask
    task automatic t_soft();
        logic ok;
        wr(8'h1c, 8'h11);
        host.wr_reg(`TCAS_I2C_ADDR, 8'h1e, 8'h01, ok);
        rchk(8'h1c, 8'h20, "soft reset threshold");
        rchk(8'h1e, 8'h00, "reset bit reads zero");
        chk({ovl, ovf}, 8'h00, "soft reset flags");
        $display("test soft reset done");
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            $display("mismatch at %0t: timeout", $time);
            final_report();
        end
    end
    initial begin
        host.tick(20);
        rst <= 1'b0;
        host.tick(4);
        t_reset();
        t_rw();
        t_detect(2'd3, 8'h02);
        t_detect(2'd2, 8'h04);
        t_wdog();
        t_detect(2'd1, 8'h08);
        t_cc();
        t_ovp();
        t_soft();
        final_report();
    end
endmodule
`default_nettype wire
